/* File: hdl/tfm_framer.sv */
// m12 framer: builds and takes apart the second-order m-frame
// How it works
// - four subframes sent in fixed cyclic order
// - six blocks per subframe, 49 bits each
// - first bit overhead, 48 information bits follow
// - alignment bits zero, one, one
// - first frame bit zero, second one
// - all stuffing-control bits mirror the stuff decision
// - receiver takes majority of control bits
// - inverted third bit means loopback, not stuffing
// - alarm bit zero while receiver out of sync
// - round-robin tributaries, two and four inverted
// - last block carries the stuffing opportunity
// - opportunity position equals subframe index plus one
`timescale 1ns/1ps
module tfm_framer (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [3:0] TRIB_DATA,
    input wire logic [3:0] STUFF_REQ,
    output logic [3:0] TRIB_TAKE,
    output logic T2_TX_DATA,
    input wire logic T2_RX_DATA,
    output logic [3:0] RX_TRIB_DATA,
    output logic [3:0] RX_TRIB_VALID,
    output logic [3:0] RX_LOOP_REQ,
    output logic RX_OOF
);
    // transmit position and per-subframe stuff decision
    logic [1:0] tsub, next_tsub;
    logic [2:0] tblk, next_tblk;
    logic [5:0] tbit, next_tbit;
    logic tstuff, next_tstuff;
    logic tx_data, next_tx_data;
    logic [1:0] ttr;
    logic tslot;

    always_comb begin
        next_tsub = tsub;
        next_tblk = tblk;
        next_tbit = tbit + 6'h01;
        next_tstuff = tstuff;
        ttr = tfm_pkg::trib_of(tbit);
        tslot = tfm_pkg::stuff_slot(tsub, tblk, tbit);
        TRIB_TAKE = 4'h0;
        if (tbit == tfm_pkg::LAST_BIT) begin
            next_tbit = tfm_pkg::OVH_BIT;
            if (tblk == tfm_pkg::LAST_BLK) begin
                next_tblk = 3'h0;
                next_tsub = tsub + 2'h1;
                // decision for the coming subframe is fixed before its C1
                next_tstuff = STUFF_REQ[next_tsub];
            end else begin
                next_tblk = tblk + 3'h1;
            end
        end
        if (tbit == tfm_pkg::OVH_BIT) begin
            // alarm is the inverse of the local out-of-sync state
            next_tx_data = tfm_pkg::ovh_bit(tsub, tblk, tstuff,
                                            ~RX_OOF);
        end else if (tslot && tstuff) begin
            next_tx_data = 1'b0;
        end else begin
            TRIB_TAKE[ttr] = 1'b1;
            next_tx_data = TRIB_DATA[ttr] ^ tfm_pkg::INV_MASK[ttr];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            tsub <= 2'h0;
            tblk <= 3'h0;
            tbit <= 6'h00;
            tstuff <= 1'b0;
            tx_data <= 1'b0;
        end else begin
            tsub <= next_tsub;
            tblk <= next_tblk;
            tbit <= next_tbit;
            tstuff <= next_tstuff;
            tx_data <= next_tx_data;
        end
    end

    assign T2_TX_DATA = tx_data;

    // receive framer: position counters, hunt by slipping one bit
    tfm_pkg::tfm_sync_type rstate, next_rstate;
    logic [1:0] rsub, next_rsub;
    logic [2:0] rblk, next_rblk;
    logic [5:0] rbit, next_rbit;
    logic [1:0] rerr, next_rerr;
    logic [3:0] rhit, next_rhit;
    logic [1:0] rc, next_rc;
    logic rstuff, next_rstuff;
    logic [3:0] rloop, next_rloop;
    logic [3:0] rdata, next_rdata;
    logic [3:0] rvalid, next_rvalid;
    logic check, miss, vstuff, vloop;
    logic [1:0] rtr;

    tfm_cvote u_vote (
        .c({T2_RX_DATA, rc}),
        .stuff(vstuff),
        .loop(vloop)
    );

    always_comb begin
        next_rstate = rstate;
        next_rsub = rsub;
        next_rblk = rblk;
        next_rbit = rbit + 6'h01;
        next_rerr = rerr;
        next_rhit = rhit;
        next_rc = rc;
        next_rstuff = rstuff;
        next_rloop = rloop;
        next_rdata = rdata;
        next_rvalid = 4'h0;
        rtr = tfm_pkg::trib_of(rbit);
        // frame and alignment bits are checked; alarm and C bits are not
        check = (rbit == tfm_pkg::OVH_BIT) &&
            ((rblk == tfm_pkg::BLK_F1) || (rblk == tfm_pkg::BLK_F2) ||
             ((rblk == tfm_pkg::BLK_MX) && (rsub != tfm_pkg::ALARM_SUB)));
        miss = check &&
            (T2_RX_DATA != tfm_pkg::ovh_bit(rsub, rblk, 1'b0, 1'b0));
        if (rbit == tfm_pkg::LAST_BIT) begin
            next_rbit = tfm_pkg::OVH_BIT;
            if (rblk == tfm_pkg::LAST_BLK) begin
                next_rblk = 3'h0;
                next_rsub = rsub + 2'h1;
            end else begin
                next_rblk = rblk + 3'h1;
            end
        end
        case (rstate)
            tfm_pkg::TFM_SYNC: begin
                if (miss) begin
                    next_rerr = rerr + 2'h1;
                    if (rerr == tfm_pkg::LOSS_ERRS - 2'h1) begin
                        next_rstate = tfm_pkg::TFM_HUNT;
                        next_rhit = 4'h0;
                    end
                end else if (check) begin
                    next_rerr = 2'h0;
                end
            end
            tfm_pkg::TFM_HUNT: begin
                if (miss) begin
                    // hold position: the candidate alignment moves one bit
                    next_rsub = rsub;
                    next_rblk = rblk;
                    next_rbit = rbit;
                    next_rhit = 4'h0;
                end else if (check) begin
                    next_rhit = rhit + 4'h1;
                    if (rhit == tfm_pkg::SYNC_HITS - 4'h1) begin
                        next_rstate = tfm_pkg::TFM_SYNC;
                        next_rerr = 2'h0;
                    end
                end
            end
            default: next_rstate = tfm_pkg::TFM_HUNT;
        endcase
        if (rbit == tfm_pkg::OVH_BIT) begin
            if (rblk == tfm_pkg::BLK_C1) begin
                next_rc[0] = T2_RX_DATA;
            end
            if (rblk == tfm_pkg::BLK_C2) begin
                next_rc[1] = T2_RX_DATA;
            end
            if (rblk == tfm_pkg::BLK_C3) begin
                next_rstuff = vstuff;
                if (rstate == tfm_pkg::TFM_SYNC) begin
                    next_rloop[rsub] = vloop;
                end
            end
        end else if (rstate == tfm_pkg::TFM_SYNC &&
                     !(tfm_pkg::stuff_slot(rsub, rblk, rbit) && rstuff)) begin
            // stuffed opportunity delivers nothing to its tributary
            next_rvalid[rtr] = 1'b1;
            next_rdata[rtr] = T2_RX_DATA ^ tfm_pkg::INV_MASK[rtr];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            rstate <= tfm_pkg::TFM_HUNT;
            rsub <= 2'h0;
            rblk <= 3'h0;
            rbit <= 6'h00;
            rerr <= 2'h0;
            rhit <= 4'h0;
            rc <= 2'h0;
            rstuff <= 1'b0;
            rloop <= 4'h0;
            rdata <= 4'h0;
            rvalid <= 4'h0;
        end else begin
            rstate <= next_rstate;
            rsub <= next_rsub;
            rblk <= next_rblk;
            rbit <= next_rbit;
            rerr <= next_rerr;
            rhit <= next_rhit;
            rc <= next_rc;
            rstuff <= next_rstuff;
            rloop <= next_rloop;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    assign RX_OOF = (rstate == tfm_pkg::TFM_HUNT);
    assign RX_TRIB_DATA = rdata;
    assign RX_TRIB_VALID = rvalid;
    assign RX_LOOP_REQ = rloop;
    // checks
    sequence s_sub_end;
        tblk == tfm_pkg::LAST_BLK && tbit == tfm_pkg::LAST_BIT;
    endsequence
    property p_sub_order;
        @(posedge REF_CLK) disable iff (RST)
        s_sub_end |=> tsub == $past(tsub) + 2'h1 && tblk == 3'h0;
    endproperty
    a_sub_order: assert property (p_sub_order)
        else $error("subframe order broken");
    property p_blk_len;
        @(posedge REF_CLK) disable iff (RST)
        tbit == tfm_pkg::OVH_BIT |=> tbit == 6'h01 ##47 tbit == 6'h30
            ##1 tbit == 6'h00;
    endproperty
    a_blk_len: assert property (p_blk_len)
        else $error("block length not 49");
    property p_ovh_no_take;
        @(posedge REF_CLK) disable iff (RST)
        tbit == tfm_pkg::OVH_BIT |-> TRIB_TAKE == 4'h0
            ##1 $onehot({tslot && tstuff, TRIB_TAKE});
    endproperty
    a_ovh_no_take: assert property (p_ovh_no_take)
        else $error("overhead slot misused");
    property p_malign;
        @(posedge REF_CLK) disable iff (RST)
        tbit == 6'h00 && tblk == 3'h0 && tsub != 2'h3
            |=> T2_TX_DATA == (tfm_pkg::M_PAT[$past(tsub)]);
    endproperty
    a_malign: assert property (p_malign)
        else $error("alignment bit wrong");
    property p_falign;
        @(posedge REF_CLK) disable iff (RST)
        tbit == 6'h00 && (tblk == 3'h2 || tblk == 3'h5)
            |=> T2_TX_DATA == ($past(tblk) == 3'h5);
    endproperty
    a_falign: assert property (p_falign)
        else $error("frame bit wrong");
    property p_cbits;
        @(posedge REF_CLK) disable iff (RST)
        tbit == 6'h00 && tblk == 3'h1 |=> T2_TX_DATA == $past(tstuff)
            ##98 T2_TX_DATA == $past(tstuff, 99)
            ##49 T2_TX_DATA == $past(tstuff, 148);
    endproperty
    a_cbits: assert property (p_cbits)
        else $error("stuff control bits disagree");
    property p_vote;
        @(posedge REF_CLK) disable iff (RST)
        rbit == 6'h00 && rblk == 3'h4 && !vloop
            |=> rstuff == ($countones({$past(T2_RX_DATA), $past(rc)}) >= 2);
    endproperty
    a_vote: assert property (p_vote)
        else $error("majority vote wrong");
    property p_loop;
        @(posedge REF_CLK) disable iff (RST)
        rbit == 6'h00 && rblk == 3'h4 && !RX_OOF
            && rc[0] == rc[1] && T2_RX_DATA != rc[0]
            |=> RX_LOOP_REQ[$past(rsub)] && !rstuff;
    endproperty
    a_loop: assert property (p_loop)
        else $error("loopback not flagged");
    property p_xbit;
        @(posedge REF_CLK) disable iff (RST)
        tbit == 6'h00 && tblk == 3'h0 && tsub == 2'h3
            |=> T2_TX_DATA == !$past(RX_OOF);
    endproperty
    a_xbit: assert property (p_xbit)
        else $error("alarm bit wrong");
    property p_invert;
        @(posedge REF_CLK) disable iff (RST)
        TRIB_TAKE[1] |=> T2_TX_DATA == !$past(TRIB_DATA[1]);
    endproperty
    a_invert: assert property (p_invert)
        else $error("tributary two not inverted");
    property p_stuff;
        @(posedge REF_CLK) disable iff (RST)
        tslot && tstuff |-> TRIB_TAKE == 4'h0 ##1 !T2_TX_DATA;
    endproperty
    a_stuff: assert property (p_stuff)
        else $error("stuff bit took data");
endmodule

/* File: hdl/tfm_pkg.sv */
// constants and shared decode for the second-order m-frame framer
package tfm_pkg;
    localparam logic [1:0] LAST_SUB = 2'h3;
    localparam logic [2:0] LAST_BLK = 3'h5;
    localparam logic [5:0] LAST_BIT = 6'h30;
    localparam logic [5:0] OVH_BIT = 6'h00;
    localparam logic [2:0] BLK_MX = 3'h0;
    localparam logic [2:0] BLK_C1 = 3'h1;
    localparam logic [2:0] BLK_F1 = 3'h2;
    localparam logic [2:0] BLK_C2 = 3'h3;
    localparam logic [2:0] BLK_C3 = 3'h4;
    localparam logic [2:0] BLK_F2 = 3'h5;
    localparam logic [1:0] ALARM_SUB = 2'h3;
    localparam logic F1_VAL = 1'h0;
    localparam logic F2_VAL = 1'h1;
    // alignment bit of subframes one to three, indexed by subframe
    localparam logic [2:0] M_PAT = 3'h6;
    // tributaries two and four travel inverted
    localparam logic [3:0] INV_MASK = 4'hA;
    localparam logic [1:0] LOSS_ERRS = 2'h3;
    localparam logic [3:0] SYNC_HITS = 4'h8;

    typedef enum logic [0:0] {
        TFM_SYNC = 1'b0,
        TFM_HUNT = 1'b1
    } tfm_sync_type;

    // overhead bit of block blk in subframe sub
    function automatic logic ovh_bit(input logic [1:0] sub,
                                     input logic [2:0] blk,
                                     input logic c, input logic x);
        logic b;
        b = 1'b0;
        case (blk)
            BLK_MX: b = (sub == ALARM_SUB) ? x : M_PAT[sub];
            BLK_C1, BLK_C2, BLK_C3: b = c;
            BLK_F1: b = F1_VAL;
            BLK_F2: b = F2_VAL;
            default: b = 1'b0;
        endcase
        return b;
    endfunction

    // true on the stuffing opportunity of subframe sub
    function automatic logic stuff_slot(input logic [1:0] sub,
                                        input logic [2:0] blk,
                                        input logic [5:0] pos);
        return (blk == LAST_BLK) && (pos == 6'({4'h0, sub}) + 6'h01);
    endfunction

    // tributary carried by information bit pos
    function automatic logic [1:0] trib_of(input logic [5:0] pos);
        logic [5:0] k;
        k = pos - 6'h01;
        return k[1:0];
    endfunction
endpackage

/* File: hdl/tfm_cvote.sv */
// stuffing-control vote and loopback pattern detector
`timescale 1ns/1ps
module tfm_cvote (
    input wire logic [2:0] c,
    output logic stuff,
    output logic loop
);
    always_comb begin
        // c[2] is the third bit; inverse of two equal bits means loopback
        loop = (c[0] == c[1]) && (c[2] != c[0]);
        // a loopback pattern is not a stuffing decision
        stuff = loop ? 1'b0 :
            ((c[0] & c[1]) | (c[0] & c[2]) | (c[1] & c[2]));
    end
endmodule

/* File: test/tfm_far_end.sv */
// far-end model: m23 stage looping the t2 stream back to the framer
`timescale 1ns/1ps
module tfm_far_end (
    input wire logic tx_bit,
    input wire logic flip,
    output logic rx_bit
);
    // bit errors come only while the bench raises flip, never on their own
    assign rx_bit = tx_bit ^ flip;
endmodule

/* File: test/test_tfm_framer.sv */
// self-checking bench for the m12 framer, looped through the far end
`timescale 1ns/1ps
module test_tfm_framer;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] trib_data = 4'h0;
    logic [3:0] stuff_req = 4'h0;
    logic [3:0] trib_take;
    logic tx;
    logic rx;
    logic flip = 1'b0;
    logic [3:0] rx_data;
    logic [3:0] rx_valid;
    logic [3:0] loop_req;
    logic oof;
    integer seed = 50097;
    integer miscompares = 0;
    integer n_compared = 0;
    integer sync_age = 0;
    integer hold = 7;
    int mode = 0;
    bit stuff_rand = 1'b1;
    logic exp_q[$];
    logic [1:0] sub = 2'h0;
    logic [2:0] blk = 3'h0;
    logic [5:0] pos = 6'h00;
    logic [1:0] psub = 2'h0;
    logic [2:0] pblk = 3'h0;
    logic [5:0] ppos = 6'h01;
    logic [3:0] stuff_dec = 4'h0;
    logic [3:0] take_d1 = 4'h0;
    logic [3:0] take_d2 = 4'h0;
    logic [3:0] dat_d1 = 4'h0;
    logic [3:0] dat_d2 = 4'h0;

    always #25 ref_clk = ~ref_clk;

    tfm_framer DUT (.REF_CLK(ref_clk), .RST(rst), .TRIB_DATA(trib_data),
        .STUFF_REQ(stuff_req), .TRIB_TAKE(trib_take), .T2_TX_DATA(tx),
        .T2_RX_DATA(rx), .RX_TRIB_DATA(rx_data), .RX_TRIB_VALID(rx_valid),
        .RX_LOOP_REQ(loop_req), .RX_OOF(oof));

    tfm_far_end far (.tx_bit(tx), .flip(flip), .rx_bit(rx));

    task automatic check(input logic [3:0] seen, input logic [3:0] want);
        n_compared++;
        if (seen !== want) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // driver: inputs change on the falling edge, expected bits are queued
    always @(negedge ref_clk) begin
        logic [3:0] take;
        logic [1:0] idx;
        logic b;
        if (hold > 0) begin
            hold--;
        end else begin
            rst = 1'b0;
            take = 4'h0;
            idx = pos[1:0] - 2'h1;
            trib_data = 4'($random(seed));
            if (pos == 6'h00 && blk == 3'h0)
                stuff_req = stuff_rand ? 4'($random(seed)) : 4'h0;
            if (pos == 6'h00) begin
                case (blk)
                    3'h0: b = (sub == 2'h3) ? ~oof : (sub != 2'h0);
                    3'h2: b = 1'b0;
                    3'h5: b = 1'b1;
                    default: b = stuff_dec[sub];
                endcase
            end else if (blk == 3'h5 && pos == {4'h0, sub} + 6'h01
                         && stuff_dec[sub]) begin
                b = 1'b0;
            end else begin
                take[idx] = 1'b1;
                b = trib_data[idx] ^ idx[0];
            end
            check(trib_take, take);
            exp_q.push_back(b);
            if (oof === 1'b0 && mode != 3)
                sync_age++;
            else
                sync_age = 0;
            // settle 100 cycles into sync before judging the demultiplexer
            if (sync_age > 100) begin
                check(rx_valid, take_d2);
                check(rx_data & rx_valid, dat_d2);
            end
            take_d2 = take_d1;
            take_d1 = take;
            dat_d2 = dat_d1;
            dat_d1 = trib_data & take;
            flip = (mode == 3)
                || (mode == 1 && pblk == 3'h4 && psub == 2'h1 && ppos == 6'h00)
                || (mode == 2 && pblk == 3'h1 && ppos == 6'h00);
            psub = sub;
            pblk = blk;
            ppos = pos;
            if (pos == 6'h30) begin
                pos = 6'h00;
                if (blk == 3'h5) begin
                    blk = 3'h0;
                    stuff_dec[sub + 2'h1] = stuff_req[sub + 2'h1];
                    sub = sub + 2'h1;
                end else begin
                    blk = blk + 3'h1;
                end
            end else begin
                pos = pos + 6'h01;
            end
        end
    end

    // monitor: each transmitted bit meets the oldest queued note
    always @(posedge ref_clk) begin
        #1;
        if (exp_q.size() > 0)
            check({3'h0, tx}, {3'h0, exp_q.pop_front()});
    end

    task automatic wait_sync();
        for (int i = 0; i < 5000 && oof !== 1'b0; i++)
            @(negedge ref_clk);
        check({3'h0, oof}, 4'h0);
    endtask

    initial begin
        wait_sync();
        repeat (2400) @(negedge ref_clk);
        stuff_rand = 1'b0;
        repeat (1200) @(negedge ref_clk);
        mode = 1;
        repeat (2400) @(negedge ref_clk);
        check(loop_req, 4'h2);
        mode = 2;
        stuff_rand = 1'b1;
        repeat (2400) @(negedge ref_clk);
        check(loop_req, 4'h0);
        mode = 3;
        // stop corrupting once sync drops: a drifted one-bit-slip hunt
        // would have to walk a whole m-frame to find alignment again
        for (int i = 0; i < 600 && oof !== 1'b1; i++)
            @(negedge ref_clk);
        check({3'h0, oof}, 4'h1);
        mode = 0;
        wait_sync();
        repeat (1200) @(negedge ref_clk);
        wrap_up();
    end

    // a hung hunt must not run forever
    initial begin
        #(50 * 30000);
        miscompares++;
        wrap_up();
    end
endmodule
